// file: pwm_consts.vh
// constants for the reduced power stage waveform generator
// assumes a 32-bit APB register port and one core clock
`ifndef PWM_CONSTS_VH
`define PWM_CONSTS_VH

// ----------------------------------------------------------------
// register byte offsets
// ----------------------------------------------------------------
`define OFF_CTRL 8'h00
`define OFF_OUT0_SET 8'h04
`define OFF_OUT0_RST 8'h08
`define OFF_OUT1_SET 8'h0C
`define OFF_OUT1_RST 8'h10
`define OFF_STATUS 8'h14
`define OFF_CAPTURE 8'h18
`define OFF_COUNTER 8'h1C

// ----------------------------------------------------------------
// control register fields
// ----------------------------------------------------------------
`define CTRL_RUN 0
`define CTRL_MODE_LO 1
`define CTRL_MODE_HI 2
`define CTRL_FIFTY 3
`define CTRL_POL0 4
`define CTRL_POL1 5
`define CTRL_CLK_PLL 6
`define CTRL_AUTO_UPDATE_LOCK 7
`define CTRL_LOCK 8
`define CTRL_SEL_A_LO 9
`define CTRL_SEL_A_HI 10
`define CTRL_SEL_B_LO 11
`define CTRL_SEL_B_HI 12
`define CTRL_FAULT_A 13
`define CTRL_FAULT_B 14
`define CTRL_IEN_EOC 15
`define CTRL_IEN_FAULT 16
`define CTRL_IEN_CAP 17
`define CTRL_INEN_A 18
`define CTRL_INEN_B 19
`define CTRL_WIDTH 20
`define CTRL_RESET 20'h00000

// ----------------------------------------------------------------
// status register fields
// ----------------------------------------------------------------
`define ST_EOC 0
`define ST_FAULT 1
`define ST_CAP 2
`define ST_RUNNING 3
`define ST_RAMP_LO 4
`define ST_RAMP_HI 5

// ----------------------------------------------------------------
// running modes and input selects
// ----------------------------------------------------------------
`define MODE_FOUR 2'h0
`define MODE_TWO 2'h1
`define MODE_ONE 2'h2
`define MODE_CENTER 2'h3
`define SEL_PIN_MAIN 2'h0
`define SEL_COMPARATOR 2'h1
`define SEL_PIN_ALT 2'h2

// ----------------------------------------------------------------
// timing figures
// ----------------------------------------------------------------
`define DT_EXTRA_FOUR 12'h002
`define RAMP_LAST_FOUR 2'h3
`define RAMP_LAST_TWO 2'h1
`define RAMP_FIRST 2'h0
`define CMP_RESET 12'h000

`endif

// file: reduced_power_stage_pwm.v
// two-output dead-time waveform generator with APB register port
// assumes APB master on core_clk; pins and io clock are asynchronous
`timescale 1ns/100ps
`include "pwm_consts.vh"

module reduced_power_stage_pwm #(
    parameter CW = 12
) (
    input wire core_clk,
    input wire rst_b,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire io_clock_in,
    input wire retrigger_pin_main,
    input wire retrigger_pin_alt_a,
    input wire retrigger_pin_alt_b,
    input wire comparator_out,
    output reg waveform_out_zero,
    output reg waveform_out_one,
    output reg generator_irq
);

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    // selects one of the input sources for a part
    function sel_input;
        input [1:0] sel;
        input main_in;
        input cmp_in;
        input alt_in;
        begin
            case (sel)
                `SEL_PIN_MAIN: sel_input = main_in;
                `SEL_COMPARATOR: sel_input = cmp_in;
                `SEL_PIN_ALT: sel_input = alt_in;
                default: sel_input = 1'b0;
            endcase
        end
    endfunction

    // last count of a ramp that must last len clocks (len zero gives one)
    function [CW-1:0] len_top;
        input [CW-1:0] len;
        begin
            if (len == `CMP_RESET) begin
                len_top = `CMP_RESET;
            end else begin
                len_top = len - 1'b1;
            end
        end
    endfunction

    // ------------------------------------------------------------
    // register state
    // ------------------------------------------------------------
    reg [`CTRL_WIDTH-1:0] ctrl_reg;
    reg [CW-1:0] sw_sa_reg, sw_ra_reg, sw_sb_reg, sw_rb_reg;
    reg [CW-1:0] act_sa_reg, act_ra_reg, act_sb_reg, act_rb_reg;
    reg [1:0] act_mode_reg;
    reg act_fifty_reg, act_pol0_reg, act_pol1_reg;
    reg rb_written_reg;
    reg [CW-1:0] cnt_reg;
    reg [1:0] ramp_reg;
    reg down_reg;
    reg running_reg;
    reg [CW-1:0] capture_reg;
    reg eoc_flag_reg, fault_flag_reg, cap_flag_reg;
    reg [4:0] sync1_reg, sync2_reg;
    reg io_last_reg;
    reg in_a_last_reg, in_b_last_reg;

    wire in_a = sel_input(ctrl_reg[`CTRL_SEL_A_HI:`CTRL_SEL_A_LO], sync2_reg[0], sync2_reg[3], sync2_reg[1]);
    wire in_b = sel_input(ctrl_reg[`CTRL_SEL_B_HI:`CTRL_SEL_B_LO], sync2_reg[0], sync2_reg[3], sync2_reg[2]);

    // ------------------------------------------------------------
    // input synchronisers
    // ------------------------------------------------------------
    // two flops on every asynchronous pin
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            sync1_reg <= 5'h00;
            sync2_reg <= 5'h00;
            io_last_reg <= 1'b0;
            in_a_last_reg <= 1'b0;
            in_b_last_reg <= 1'b0;
        end else begin
            sync1_reg <= {io_clock_in, comparator_out, retrigger_pin_alt_b, retrigger_pin_alt_a, retrigger_pin_main};
            sync2_reg <= sync1_reg;
            io_last_reg <= sync2_reg[4];
            in_a_last_reg <= in_a;
            in_b_last_reg <= in_b;
        end
    end

    // pll runs every clock, io clock on its synchronised edge
    wire gen_tick = ctrl_reg[`CTRL_CLK_PLL] | (sync2_reg[4] & ~io_last_reg);

    // ------------------------------------------------------------
    // input events
    // ------------------------------------------------------------
    wire edge_a = ctrl_reg[`CTRL_INEN_A] & in_a & ~in_a_last_reg;
    wire edge_b = ctrl_reg[`CTRL_INEN_B] & in_b & ~in_b_last_reg;
    wire fault_a = ctrl_reg[`CTRL_INEN_A] & ctrl_reg[`CTRL_FAULT_A] & in_a;
    wire fault_b = ctrl_reg[`CTRL_INEN_B] & ctrl_reg[`CTRL_FAULT_B] & in_b;
    wire cap_event = (edge_a & ~ctrl_reg[`CTRL_FAULT_A]) | (edge_b & ~ctrl_reg[`CTRL_FAULT_B]);

    // ------------------------------------------------------------
    // effective compare values
    // ------------------------------------------------------------
    // part A follows part B in fifty-percent configuration
    wire [CW-1:0] use_sa = act_fifty_reg ? act_sb_reg : act_sa_reg;
    wire [CW-1:0] use_ra = act_fifty_reg ? act_rb_reg : act_ra_reg;

    // ------------------------------------------------------------
    // ramp bounds
    // ------------------------------------------------------------
    reg [CW-1:0] top;
    reg last_ramp;
    // four-ramp on ramps last reset value
    // four-ramp dead ramps last set value plus two
    always @* begin
        top = act_rb_reg;
        last_ramp = 1'b1;
        case (act_mode_reg)
            `MODE_FOUR: begin
                last_ramp = (ramp_reg == `RAMP_LAST_FOUR);
                case (ramp_reg)
                    2'h0: top = len_top(use_sa + `DT_EXTRA_FOUR);
                    2'h1: top = len_top(use_ra);
                    2'h2: top = len_top(act_sb_reg + `DT_EXTRA_FOUR);
                    default: top = len_top(act_rb_reg);
                endcase
            end
            `MODE_TWO: begin
                last_ramp = (ramp_reg == `RAMP_LAST_TWO);
                top = (ramp_reg == `RAMP_FIRST) ? use_ra : act_rb_reg;
            end
            default: begin
                top = act_rb_reg;
                last_ramp = 1'b1;
            end
        endcase
    end

    wire center = (act_mode_reg == `MODE_CENTER);
    // start uses the set that is loaded on that same edge
    wire center_sw = (ctrl_reg[`CTRL_MODE_HI:`CTRL_MODE_LO] == `MODE_CENTER);
    wire at_top = (cnt_reg == top);
    // cycle end only at top of sub-cycle B's last ramp
    // center cycle ends on reaching top while rising
    wire eoc = running_reg & gen_tick & at_top & last_ramp & (~center | ~down_reg);

    // ------------------------------------------------------------
    // output activity
    // ------------------------------------------------------------
    reg act0, act1;
    // part A active in sub-cycle A, part B in sub-cycle B
    // two-ramp dead time covers counts 0..set value
    // on-time spans set value exclusive to reset value
    // one-ramp outputs compared on one shared ramp
    always @* begin
        case (act_mode_reg)
            `MODE_FOUR: begin
                act0 = (ramp_reg == 2'h1) && (use_ra != `CMP_RESET);
                act1 = (ramp_reg == 2'h3) && (act_rb_reg != `CMP_RESET);
            end
            `MODE_TWO: begin
                act0 = (ramp_reg == `RAMP_FIRST) && (cnt_reg > use_sa);
                act1 = (ramp_reg == `RAMP_LAST_TWO) && (cnt_reg > act_sb_reg);
            end
            default: begin
                act0 = (cnt_reg > use_sa) && (cnt_reg <= use_ra);
                act1 = (cnt_reg > act_sb_reg) && (cnt_reg <= act_rb_reg);
            end
        endcase
    end

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    wire setup = psel & ~penable;
    wire wr_done = psel & penable & pready & pwrite;
    wire mapped = (paddr == `OFF_CTRL) || (paddr == `OFF_OUT0_SET) || (paddr == `OFF_OUT0_RST) ||
                  (paddr == `OFF_OUT1_SET) || (paddr == `OFF_OUT1_RST) || (paddr == `OFF_STATUS) ||
                  (paddr == `OFF_CAPTURE) || (paddr == `OFF_COUNTER);
    wire wr_ok = wr_done & mapped;
    wire stop_now = ~ctrl_reg[`CTRL_RUN];

    // out1 reset write arms auto lock transfer
    // auto lock decides before the lock bit
    wire allow = ctrl_reg[`CTRL_AUTO_UPDATE_LOCK] ? rb_written_reg : ~ctrl_reg[`CTRL_LOCK];
    // stopped generator follows writes at once
    // running generator loads the whole set at cycle end
    wire load_set = ~running_reg | (eoc & allow);

    // read mux and handshake
    reg [31:0] rd_next;
    always @* begin
        rd_next = 32'h00000000;
        case (paddr)
            `OFF_CTRL: rd_next[`CTRL_WIDTH-1:0] = ctrl_reg;
            `OFF_OUT0_SET: rd_next[CW-1:0] = sw_sa_reg;
            `OFF_OUT0_RST: rd_next[CW-1:0] = sw_ra_reg;
            `OFF_OUT1_SET: rd_next[CW-1:0] = sw_sb_reg;
            `OFF_OUT1_RST: rd_next[CW-1:0] = sw_rb_reg;
            `OFF_STATUS: begin
                rd_next[`ST_EOC] = eoc_flag_reg;
                rd_next[`ST_FAULT] = fault_flag_reg;
                rd_next[`ST_CAP] = cap_flag_reg;
                rd_next[`ST_RUNNING] = running_reg;
                rd_next[`ST_RAMP_HI:`ST_RAMP_LO] = ramp_reg;
            end
            `OFF_CAPTURE: rd_next[CW-1:0] = capture_reg;
            `OFF_COUNTER: rd_next[CW-1:0] = cnt_reg;
            default: rd_next = 32'h00000000;
        endcase
    end

    // apb answer one cycle after setup
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= setup;
            pslverr <= setup & ~mapped;
            if (setup && !pwrite) begin
                prdata <= rd_next;
            end
        end
    end

    // ------------------------------------------------------------
    // software registers
    // ------------------------------------------------------------
    // 12-bit compare values
    // software writes values and run bit
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            ctrl_reg <= `CTRL_RESET;
            sw_sa_reg <= `CMP_RESET;
            sw_ra_reg <= `CMP_RESET;
            sw_sb_reg <= `CMP_RESET;
            sw_rb_reg <= `CMP_RESET;
            rb_written_reg <= 1'b0;
        end else begin
            if (wr_ok && paddr == `OFF_CTRL) begin
                ctrl_reg <= pwdata[`CTRL_WIDTH-1:0];
            end
            if (wr_ok && paddr == `OFF_OUT0_SET) begin
                sw_sa_reg <= pwdata[CW-1:0];
            end
            if (wr_ok && paddr == `OFF_OUT0_RST) begin
                sw_ra_reg <= pwdata[CW-1:0];
            end
            if (wr_ok && paddr == `OFF_OUT1_SET) begin
                sw_sb_reg <= pwdata[CW-1:0];
            end
            if (wr_ok && paddr == `OFF_OUT1_RST) begin
                sw_rb_reg <= pwdata[CW-1:0];
            end
            // a new arming write wins over the clearing transfer
            if (wr_ok && paddr == `OFF_OUT1_RST) begin
                rb_written_reg <= 1'b1;
            end else if (eoc && allow) begin
                rb_written_reg <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // active value set
    // ------------------------------------------------------------
    // compare values, mode and polarity move together
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            act_sa_reg <= `CMP_RESET;
            act_ra_reg <= `CMP_RESET;
            act_sb_reg <= `CMP_RESET;
            act_rb_reg <= `CMP_RESET;
            act_mode_reg <= `MODE_FOUR;
            act_fifty_reg <= 1'b0;
            act_pol0_reg <= 1'b0;
            act_pol1_reg <= 1'b0;
        end else if (load_set) begin
            act_sa_reg <= sw_sa_reg;
            act_ra_reg <= sw_ra_reg;
            act_sb_reg <= sw_sb_reg;
            act_rb_reg <= sw_rb_reg;
            act_mode_reg <= ctrl_reg[`CTRL_MODE_HI:`CTRL_MODE_LO];
            act_fifty_reg <= ctrl_reg[`CTRL_FIFTY];
            act_pol0_reg <= ctrl_reg[`CTRL_POL0];
            act_pol1_reg <= ctrl_reg[`CTRL_POL1];
        end
    end

    // ------------------------------------------------------------
    // counter and ramp sequencer
    // ------------------------------------------------------------
    // single counter stepped by mode
    // ramps sum to on-times plus dead-times
    // start clears counter into sub-cycle A, or in center mode loads out1 reset value counting down
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            cnt_reg <= `CMP_RESET;
            ramp_reg <= `RAMP_FIRST;
            down_reg <= 1'b0;
            running_reg <= 1'b0;
        end else if (stop_now) begin
            running_reg <= 1'b0;
            cnt_reg <= `CMP_RESET;
            ramp_reg <= `RAMP_FIRST;
            down_reg <= 1'b0;
        end else if (!running_reg) begin
            running_reg <= 1'b1;
            ramp_reg <= `RAMP_FIRST;
            down_reg <= center_sw;
            cnt_reg <= center_sw ? sw_rb_reg : `CMP_RESET;
        end else if (gen_tick) begin
            if (center) begin
                if (down_reg) begin
                    if (cnt_reg == `CMP_RESET) begin
                        down_reg <= 1'b0;
                        cnt_reg <= cnt_reg + 1'b1;
                    end else begin
                        cnt_reg <= cnt_reg - 1'b1;
                    end
                end else if (at_top) begin
                    down_reg <= 1'b1;
                    if (cnt_reg != `CMP_RESET) begin
                        cnt_reg <= cnt_reg - 1'b1;
                    end
                end else begin
                    cnt_reg <= cnt_reg + 1'b1;
                end
            end else if (at_top) begin
                cnt_reg <= `CMP_RESET;
                ramp_reg <= last_ramp ? `RAMP_FIRST : ramp_reg + 1'b1;
            end else begin
                cnt_reg <= cnt_reg + 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // outputs, capture and flags
    // ------------------------------------------------------------
    // level inverted, timing kept
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            waveform_out_zero <= 1'b1;
            waveform_out_one <= 1'b1;
        end else begin
            waveform_out_zero <= (running_reg & act0 & ~fault_a) ? act_pol0_reg : ~act_pol0_reg;
            waveform_out_one <= (running_reg & act1 & ~fault_b) ? act_pol1_reg : ~act_pol1_reg;
        end
    end

    wire clr_st = wr_ok & (paddr == `OFF_STATUS);

    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            capture_reg <= `CMP_RESET;
            eoc_flag_reg <= 1'b0;
            fault_flag_reg <= 1'b0;
            cap_flag_reg <= 1'b0;
            generator_irq <= 1'b0;
        end else begin
            if (cap_event) begin
                capture_reg <= cnt_reg;
            end
            // set wins over write-one clear
            eoc_flag_reg <= eoc | (eoc_flag_reg & ~(clr_st & pwdata[`ST_EOC]));
            fault_flag_reg <= fault_a | fault_b | (fault_flag_reg & ~(clr_st & pwdata[`ST_FAULT]));
            cap_flag_reg <= cap_event | (cap_flag_reg & ~(clr_st & pwdata[`ST_CAP]));
            generator_irq <= (eoc_flag_reg & ctrl_reg[`CTRL_IEN_EOC]) |
                             (fault_flag_reg & ctrl_reg[`CTRL_IEN_FAULT]) |
                             (cap_flag_reg & ctrl_reg[`CTRL_IEN_CAP]);
        end
    end

endmodule

// file: pwm_port_chk.sv
// port checker for the waveform generator
// assumes apb writes land at the handshake edge
`timescale 1ns/100ps
module pwm_port_chk (
    input wire core_clk,
    input wire rst_b,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    input wire pready,
    input wire pslverr,
    input wire waveform_out_zero,
    input wire waveform_out_one,
    input wire generator_irq
);
    // ----------------------------------------
    // control shadow and checks
    // ----------------------------------------
    reg [19:0] ctl_reg;
    wire setup = psel && !penable;
    wire act0 = waveform_out_zero == ctl_reg[4];
    wire act1 = waveform_out_one == ctl_reg[5];

    // copy of control after each write
    always @(posedge core_clk or negedge rst_b) begin
        if (!rst_b)
            ctl_reg <= 20'h00000;
        else if (psel && penable && pready && pwrite && paddr == 8'h00)
            ctl_reg <= pwdata[19:0];
    end

    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    AST_PREADY_NEXT: assert property (setup |=> pready) // apb answer
        else $error("pready missing after setup");
    AST_PREADY_PULSE: assert property (pready |=> !pready) // apb answer
        else $error("pready longer than one cycle");
    AST_PREADY_CAUSE: assert property (pready |-> $past(setup)) // apb answer
        else $error("pready without setup");
    AST_ERR_UNMAPPED: assert property (setup && paddr > 8'h1C |=> pslverr) // apb refusal
        else $error("no error on unmapped address");
    AST_ERR_MAPPED: assert property (setup && paddr < 8'h20 && paddr[1:0] == 2'h0 |=> !pslverr) // apb map
        else $error("error on mapped address");
    AST_STOP_IDLE: assert property ((!ctl_reg[0] && $stable(ctl_reg))[*3] |-> !act0 && !act1)
        else $error("output active while stopped");
    AST_NO_OVERLAP: assert property ((ctl_reg[0] && !ctl_reg[2])[*3] |-> !(act0 && act1))
        else $error("outputs overlap in ramp mode");
    AST_IRQ_MASKED: assert property ((ctl_reg[17:15] == 3'h0)[*2] |-> !generator_irq)
        else $error("irq with all sources disabled");

    cover property (setup && paddr > 8'h1C);
    cover property ($rose(generator_irq));
    cover property (ctl_reg[0] && act1);
endmodule

bind reduced_power_stage_pwm pwm_port_chk u_chk (
    .core_clk(core_clk),
    .rst_b(rst_b),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .pready(pready),
    .pslverr(pslverr),
    .waveform_out_zero(waveform_out_zero),
    .waveform_out_one(waveform_out_one),
    .generator_irq(generator_irq)
);

// file: gate_stage_model.sv
// driver stage model timing the gate pulses
// assumes active-low outputs, as after reset
`timescale 1ns/100ps
module gate_stage_model (
    input wire clk,
    input wire rst_b,
    input wire gate_zero,
    input wire gate_one,
    output reg [11:0] on0_len,
    output reg [11:0] on1_len,
    output reg [11:0] period_len
);
    reg [11:0] c0, c1, cp;
    reg prev0;

    // time each pulse and the fall-to-fall period of gate_zero
    always @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            {c0, c1, cp, on0_len, on1_len, period_len} <= 72'h0;
            prev0 <= 1'b0;
        end else begin
            c0 <= gate_zero ? 12'h000 : c0 + 12'h001;
            c1 <= gate_one ? 12'h000 : c1 + 12'h001;
            if (gate_zero && c0 != 12'h000)
                on0_len <= c0;
            if (gate_one && c1 != 12'h000)
                on1_len <= c1;
            prev0 <= !gate_zero;
            cp <= (!gate_zero && !prev0) ? 12'h001 : cp + 12'h001;
            if (!gate_zero && !prev0)
                period_len <= cp;
        end
    end
endmodule

// file: test_reduced_power_stage_pwm.sv
// self-checking bench for the waveform generator
// assumes one-access apb slave and a passive gate stage
`timescale 1ns/100ps
`include "pwm_consts.vh"
module test_reduced_power_stage_pwm;
    // ----------------------------------------
    // stimulus, design and stage
    // ----------------------------------------
    reg core_clk = 1'b0;
    reg rst_b = 1'b0;
    reg psel = 1'b0;
    reg penable = 1'b0;
    reg pwrite = 1'b0;
    reg [7:0] paddr = 8'h00;
    reg [31:0] pwdata = 32'h0;
    reg io_clock_in = 1'b0;
    reg pin_lvl = 1'b0;
    wire [31:0] prdata;
    wire pready, pslverr, out0, out1, irq;
    wire [11:0] on0, on1, per;
    reg [31:0] rd;
    reg er;
    integer mismatches = 0;
    integer compares = 0;
    integer cyc = 0;

    // core clock and slow io clock
    always #2.5 core_clk = ~core_clk;
    always @(posedge core_clk) io_clock_in <= ~io_clock_in;

    reduced_power_stage_pwm u_dut (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .psel(psel),
        .penable(penable),
        .pwrite(pwrite),
        .paddr(paddr),
        .pwdata(pwdata),
        .prdata(prdata),
        .pready(pready),
        .pslverr(pslverr),
        .io_clock_in(io_clock_in),
        .retrigger_pin_main(pin_lvl),
        .retrigger_pin_alt_a(pin_lvl),
        .retrigger_pin_alt_b(pin_lvl),
        .comparator_out(pin_lvl),
        .waveform_out_zero(out0),
        .waveform_out_one(out1),
        .generator_irq(irq)
    );
    gate_stage_model u_stage (
        .clk(core_clk),
        .rst_b(rst_b),
        .gate_zero(out0),
        .gate_one(out1),
        .on0_len(on0),
        .on1_len(on1),
        .period_len(per)
    );

    task check(input logic [31:0] seen, input logic [31:0] exp);
        compares = compares + 1;
        if (seen !== exp) begin
            mismatches = mismatches + 1;
            $display("[ERR] %0t seen %h exp %h", $time, seen, exp);
        end
    endtask

    task final_report;
        if (mismatches == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    task wt(input integer n);
        repeat (n) @(posedge core_clk);
    endtask

    // one apb transfer, keeps read data and error
    task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        @(posedge core_clk);
        while (pready !== 1'b1) begin
            @(posedge core_clk);
        end
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask

    // software writes the four compare values of the set
    task prog(input logic [11:0] s0, r0, s1, r1);
        apb(1'b1, `OFF_OUT0_SET, {20'h00000, s0});
        apb(1'b1, `OFF_OUT0_RST, {20'h00000, r0});
        apb(1'b1, `OFF_OUT1_SET, {20'h00000, s1});
        apb(1'b1, `OFF_OUT1_RST, {20'h00000, r1});
    endtask

    // run, time the pulses, then stop
    task run_meas(input logic [31:0] c, input logic [11:0] e0, e1, ep);
        apb(1'b1, `OFF_CTRL, c);
        wt(60);
        check(on0, e0);
        check(on1, e1);
        check(per, ep);
        apb(1'b1, `OFF_CTRL, 32'h0);
        wt(3);
        check({out1, out0}, 2'h3);
    endtask

    task t_regs;
        check({out1, out0}, 2'h3);
        apb(1'b1, `OFF_OUT1_SET, 32'hFFFFFABC);
        apb(1'b0, `OFF_OUT1_SET, 32'h0);
        check(rd, 32'h00000ABC);
        apb(1'b0, 8'h20, 32'h0);
        check({rd[30:0], er}, 32'h1);
        apb(1'b1, `OFF_CTRL, 32'h10);
        wt(3);
        check(out0, 1'b0);
        apb(1'b1, `OFF_CTRL, 32'h0);
    endtask

    task t_four;
        prog(12'h001, 12'h003, 12'h002, 12'h004);
        run_meas(32'h41, 12'h003, 12'h004, 12'h00E);
    endtask

    task t_two;
        prog(12'h001, 12'h005, 12'h002, 12'h006);
        run_meas(32'h43, 12'h004, 12'h004, 12'h00D);
    endtask

    task t_fifty;
        prog(12'h000, 12'h000, 12'h002, 12'h005);
        run_meas(32'h49, 12'h005, 12'h005, 12'h012);
    endtask

    // one ramp, then centered on the same set
    task t_one;
        prog(12'h001, 12'h003, 12'h004, 12'h006);
        run_meas(32'h45, 12'h002, 12'h002, 12'h007);
        apb(1'b1, `OFF_CTRL, 32'h47);
        wt(60);
        check(on1, 12'h003);
        apb(1'b1, `OFF_CTRL, 32'h0);
    endtask

    // capture edge on part A, fault level on part B
    task t_cap;
        apb(1'b1, `OFF_CTRL, 32'h000C4041);
        wt(4);
        pin_lvl <= 1'b1;
        wt(8);
        apb(1'b0, `OFF_STATUS, 32'h0);
        check(rd[2], 1'b1);
        check(rd[1], 1'b1);
        pin_lvl <= 1'b0;
        apb(1'b1, `OFF_CTRL, 32'h0);
    endtask

    task t_lock;
        prog(12'h001, 12'h003, 12'h002, 12'h004);
        apb(1'b1, `OFF_CTRL, 32'h141);
        wt(40);
        apb(1'b1, `OFF_OUT0_RST, 32'h6);
        wt(40);
        check(on0, 12'h003);
        apb(1'b1, `OFF_CTRL, 32'h41);
        wt(60);
        check(on0, 12'h006);
        check(per, 12'h011);
        apb(1'b1, `OFF_CTRL, 32'h0);
    endtask

    task t_irq;
        integer n;
        n = 0;
        apb(1'b1, `OFF_STATUS, 32'h7);
        apb(1'b0, `OFF_STATUS, 32'h0);
        check(rd[2:0], 3'h0);
        apb(1'b1, `OFF_CTRL, 32'h8041);
        while (irq !== 1'b1 && n < 100) begin
            n = n + 1;
            @(posedge core_clk);
        end
        check(irq, 1'b1);
        apb(1'b0, `OFF_STATUS, 32'h0);
        check(rd[0], 1'b1);
        apb(1'b1, `OFF_CTRL, 32'h8000);
        apb(1'b1, `OFF_STATUS, 32'h1);
        wt(3);
        check(irq, 1'b0);
        apb(1'b1, `OFF_CTRL, 32'h0);
    endtask

    // main sequence
    initial begin
        wt(10);
        rst_b <= 1'b1;
        wt(1);
        t_regs;
        t_four;
        t_two;
        t_fifty;
        t_one;
        t_lock;
        t_cap;
        t_irq;
        final_report;
    end

    // cut a hang short
    always @(posedge core_clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            mismatches = mismatches + 1;
            final_report;
        end
    end
endmodule
